// File: hw/pie_defs.svh
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH
// phase counter runs t0..t8
`define PIE_PHASE_LAST   4'h8
`define PIE_PHASE_T0     4'h0
`define PIE_PHASE_T4     4'h4
`define PIE_PHASE_T6     4'h6
// insert mode code loaded into the program mode latch
`define PIE_MODE_INSERT  2'h3
`define PIE_MODE_MANUAL  2'h0
// debounce delay in clock cycles
`define PIE_DEBOUNCE_CYC 4'h9
// marker counter width and reset value
`define PIE_MARKER_W     9
`define PIE_MARKER_RST   9'h000
`endif

// File: hw/pie_pkg.sv
`default_nettype none
package pie_pkg;
  // key events from the keyboard scanner and slot events from the shift registers
  typedef struct packed {
    logic insertKey;     // insert key decoded and held
    logic instrKey;      // instruction key decoded and held
    logic resetKey;      // reset key pressed
    logic firstData;     // first data event
    logic nullOut;       // null word leaving the shift registers
    logic [8:0] slotIdx; // slot index leaving the shift registers
  } pie_key_type;
  // path select levels toward the shift register input
  typedef struct packed {
    logic counterSourceSelectN; // low selects key-scan counter
    logic delayPathSelect;      // high selects delayed data path when counterSourceSelectN is high
  } pie_path_type;
endpackage : pie_pkg
`default_nettype wire

// File: hw/pie_phase_counter.sv
`default_nettype none
`include "pie_defs.svh"
module pie_phase_counter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // phase outputs
  output logic [3:0]      phase,
  output logic            phaseT04,
  output logic            phaseT6
);
  typedef struct packed {
    logic [3:0] ph;
  } pie_ph_state_type;
  pie_ph_state_type st_reg; // phase state
  pie_ph_state_type st_next;

  // advance t0..t8 and wrap
  always_comb begin
    st_next = st_reg;
    if (st_reg.ph == `PIE_PHASE_LAST) begin
      st_next.ph = `PIE_PHASE_T0;
    end else begin
      st_next.ph = st_reg.ph + 4'h1;
    end
  end

  // register the phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase    = st_reg.ph;
  assign phaseT04 = (st_reg.ph == `PIE_PHASE_T0) ||
                    (st_reg.ph == `PIE_PHASE_T4);
  assign phaseT6  = (st_reg.ph == `PIE_PHASE_T6);

  // phase never leaves range
  property p_phase_range;
    @(posedge clk) disable iff (!rst_b) st_reg.ph <= `PIE_PHASE_LAST;
  endproperty
  a_phase_range: assert property (p_phase_range)
    else $error("phase out of range");
endmodule // pie_phase_counter
`default_nettype wire

// File: hw/pie_debounce.sv
`default_nettype none
`include "pie_defs.svh"
module pie_debounce (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  // result
  output logic            expired
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       run;
    logic       done;
  } pie_db_state_type;
  pie_db_state_type st_reg; // debounce state
  pie_db_state_type st_next;

  // count the bounce delay once started
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (abort) begin
      st_next.run = 1'b0;
      st_next.cnt = 4'h0;
    end else if (start && !st_reg.run) begin
      st_next.run = 1'b1;
      st_next.cnt = 4'h0;
    end else if (st_reg.run) begin
      if (st_reg.cnt == `PIE_DEBOUNCE_CYC - 4'h1) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
  end

  // register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.done;
endmodule // pie_debounce
`default_nettype wire

// File: hw/pie_insert_ctrl.sv
`default_nettype none
`include "pie_defs.svh"
module pie_insert_ctrl (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // keyboard events
  input  wire pie_pkg::pie_key_type keyIn,
  // key-scan counter data, delayed data and direct data
  input  wire logic [7:0]           keyScanData,
  input  wire logic [7:0]           delayedData,
  input  wire logic [7:0]           directData,
  // mode and status
  output logic [1:0]                programModeLatch,
  output logic                      modeLoadStrobeN,
  output logic                      insertModeActiveN,
  output logic                      programModePulse,
  output logic                      keyboardSkipEnable,
  output logic                      insertConstant,
  output logic                      insertConstantN,
  output logic                      editStatusLatch,
  output logic                      keySeen,
  output logic                      scanHalt,
  // insert sequencing
  output logic                      firstDataPending,
  output logic                      markerZeroFlag,
  output logic                      markerPendingFlag,
  output logic                      insertWritePermitN,
  output logic                      deleteInsertFlag,
  output pie_pkg::pie_path_type     pathSel,
  output logic [`PIE_MARKER_W-1:0]  markerCount,
  output logic [7:0]                shiftInData
);
  // phase taps and debounce expiry
  logic [3:0] phase;
  logic       phaseT04;
  logic       phaseT6;
  logic       dbExpired;

  // all block state
  typedef struct packed {
    logic       keySeen;      // key-seen
    logic       debounced;    // debounced key
    logic       clrDebounce;  // clear-debounce latch
    logic       decoderOff;   // mode decoder disabled
    logic [1:0] modeLatch;    // program mode latch
    logic       insertMode;   // insert mode levels held
    logic       progMode;     // program mode flip-flop
    logic       deleteNull;   // delete-or-null flag
    logic       falseFirst;   // false-first-data flag
    logic       editLatch;    // edit status latch
    logic       pending;      // first data pending
    logic       mZero;        // marker zero flag
    logic       mPend;        // marker pending flag
    logic       delIns;       // delete/insert flag
    logic       nullSeen;     // null permits reset
    logic [`PIE_MARKER_W-1:0] marker;
    logic [7:0] dataOut;      // shift register input word
    logic       outStrobeN;
    logic       outActiveN;
    logic       outConst;
    logic       outSkip;
    logic       outPermitN;
    logic       outSrcN;
    logic       outDelay;
  } pie_state_type;
  pie_state_type st_reg;
  pie_state_type st_next;

  // phase counter
  pie_phase_counter uPhase (
    .clk      (clk),
    .rst_b    (rst_b),
    .phase    (phase),
    .phaseT04 (phaseT04),
    .phaseT6  (phaseT6)
  );

  // bounce delay timer
  pie_debounce uDebounce (
    .clk     (clk),
    .rst_b   (rst_b),
    .start   (st_reg.keySeen && !st_reg.debounced),
    .abort   (!(keyIn.insertKey || keyIn.instrKey)),
    .expired (dbExpired)
  );

  // next state of the whole block
  always_comb begin
    logic permitN;
    logic srcN;
    logic dly;
    st_next = st_reg;
    permitN = 1'b1;
    srcN    = 1'b1;
    dly     = 1'b0;
    // key-seen follows a decoded key
    st_next.keySeen = keyIn.insertKey || keyIn.instrKey;
    if (dbExpired && st_reg.keySeen) begin
      st_next.debounced = 1'b1;
    end
    // debounced insert key loads mode 3
    if (st_reg.debounced && keyIn.insertKey && !st_reg.insertMode) begin
      st_next.modeLatch   = `PIE_MODE_INSERT;
      st_next.decoderOff  = 1'b1;
      st_next.clrDebounce = 1'b1;
      st_next.progMode    = 1'b1;
    end
    // program mode holds while key held
    if (!st_reg.keySeen) begin
      st_next.progMode = 1'b0;
    end
    // debounced clears at t6
    if (phaseT6 && st_reg.debounced) begin
      st_next.debounced   = 1'b0;
      st_next.clrDebounce = 1'b0;
      st_next.decoderOff  = 1'b0;
      // only the entry into insert mode arms the false-first flag,
      // later instruction debounces must leave it cleared
      if (st_reg.modeLatch == `PIE_MODE_INSERT && !st_reg.insertMode) begin
        st_next.insertMode = 1'b1;
        st_next.editLatch  = 1'b1;
        st_next.falseFirst = 1'b1;
      end
    end
    // program pulse clears delete-or-null
    if (st_reg.progMode) begin
      st_next.deleteNull = 1'b0;
    end
    // first data after release clears false flag
    if (keyIn.firstData && !st_reg.progMode && st_reg.insertMode) begin
      st_next.falseFirst = 1'b0;
    end
    // instruction key debounced then first data presets pending
    if (st_reg.insertMode && keyIn.instrKey && st_reg.debounced) begin
      st_next.mPend = 1'b1;
    end
    if (st_reg.insertMode && keyIn.firstData && st_reg.mPend) begin
      st_next.pending = 1'b1;
    end
    // marker zero at insertion slot on t0/t4
    if (phaseT04 && st_reg.pending && st_reg.marker == keyIn.slotIdx
        && !st_reg.mZero) begin
      st_next.mZero  = 1'b1;
      st_next.mPend  = 1'b0;
      st_next.marker = st_reg.marker - 9'h001;
    end
    permitN = !(st_reg.mZero && st_reg.pending);
    // t0/t4 ends the write and starts delayed path
    if (phaseT04 && st_reg.mZero && !permitN) begin
      st_next.mZero    = 1'b0;
      st_next.pending  = 1'b0;
      st_next.delIns   = 1'b1;
      st_next.nullSeen = 1'b0;
    end
    // first null permits end of delayed path
    if (st_reg.delIns && keyIn.nullOut) begin
      st_next.nullSeen = 1'b1;
    end
    if (phaseT04 && st_reg.delIns && st_reg.nullSeen) begin
      st_next.delIns   = 1'b0;
      st_next.nullSeen = 1'b0;
    end
    // path select
    srcN = permitN;
    dly  = st_reg.delIns || !permitN;
    if (!srcN) begin
      st_next.dataOut = keyScanData;
    end else if (dly) begin
      st_next.dataOut = delayedData;
    end else begin
      st_next.dataOut = directData;
    end
    // reset key returns to manual mode
    if (keyIn.resetKey) begin
      st_next.insertMode = 1'b0;
      st_next.editLatch  = 1'b0;
      st_next.modeLatch  = `PIE_MODE_MANUAL;
      st_next.delIns     = 1'b0;
      st_next.mZero      = 1'b0;
      st_next.pending    = 1'b0;
      st_next.mPend      = 1'b0;
    end
    // registered output levels
    st_next.outStrobeN = !st_next.clrDebounce;
    st_next.outActiveN = !st_next.insertMode;
    st_next.outConst   = st_next.insertMode;
    st_next.outSkip    = !st_next.insertMode;
    st_next.outPermitN = permitN;
    st_next.outSrcN    = srcN;
    st_next.outDelay   = dly;
  end

  // register state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg            <= '0;
      st_reg.outStrobeN <= 1'b1;
      st_reg.outActiveN <= 1'b1;
      st_reg.outSkip    <= 1'b1;
      st_reg.outPermitN <= 1'b1;
      st_reg.outSrcN    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from flip-flops
  assign programModeLatch     = st_reg.modeLatch;
  assign modeLoadStrobeN      = st_reg.outStrobeN;
  assign insertModeActiveN    = st_reg.outActiveN;
  assign programModePulse     = st_reg.progMode;
  assign keyboardSkipEnable   = st_reg.outSkip;
  assign insertConstant       = st_reg.outConst;
  assign insertConstantN      = st_reg.outActiveN;
  assign editStatusLatch      = st_reg.editLatch;
  assign keySeen              = st_reg.keySeen;
  assign scanHalt             = st_reg.keySeen;
  assign firstDataPending     = st_reg.pending;
  assign markerZeroFlag       = st_reg.mZero;
  assign markerPendingFlag    = st_reg.mPend;
  assign insertWritePermitN   = st_reg.outPermitN;
  assign deleteInsertFlag     = st_reg.delIns;
  assign pathSel.counterSourceSelectN = st_reg.outSrcN;
  assign pathSel.delayPathSelect      = st_reg.outDelay;
  assign markerCount          = st_reg.marker;
  assign shiftInData          = st_reg.dataOut;

  // checks
  property p_t6_clear;
    @(posedge clk) disable iff (!rst_b)
      (phaseT6 && st_reg.debounced) |=> !st_reg.debounced;
  endproperty
  a_t6_clear: assert property (p_t6_clear)
    else $error("debounced not cleared at t6");

  property p_const_pair;
    @(posedge clk) disable iff (!rst_b)
      insertConstant != insertConstantN;
  endproperty
  a_const_pair: assert property (p_const_pair)
    else $error("insert constant pair broken");

  property p_skip_block;
    @(posedge clk) disable iff (!rst_b)
      st_reg.insertMode |-> !keyboardSkipEnable;
  endproperty
  a_skip_block: assert property (p_skip_block)
    else $error("skip enable not blocked");

  property p_retard;
    @(posedge clk) disable iff (!rst_b)
      $rose(st_reg.mZero) |-> st_reg.marker == $past(st_reg.marker) - 9'h001;
  endproperty
  a_retard: assert property (p_retard)
    else $error("marker not retarded");

  property p_zero_phase;
    @(posedge clk) disable iff (!rst_b)
      $rose(st_reg.mZero) |-> $past(phaseT04);
  endproperty
  a_zero_phase: assert property (p_zero_phase)
    else $error("marker zero off phase");

  property p_delins_set;
    @(posedge clk) disable iff (!rst_b)
      $rose(st_reg.delIns) |-> $past(phaseT04) && !st_reg.mZero;
  endproperty
  a_delins_set: assert property (p_delins_set)
    else $error("delete/insert set badly");

  property p_delins_end;
    @(posedge clk) disable iff (!rst_b)
      $fell(st_reg.delIns) && !$past(keyIn.resetKey)
        |-> $past(phaseT04) && $past(st_reg.nullSeen);
  endproperty
  a_delins_end: assert property (p_delins_end)
    else $error("delete/insert ended early");

  property p_reset_manual;
    @(posedge clk) disable iff (!rst_b)
      keyIn.resetKey |=> ##1 insertModeActiveN;
  endproperty
  a_reset_manual: assert property (p_reset_manual)
    else $error("reset key ignored");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
      !st_reg.keySeen |=> !st_reg.progMode;
  endproperty
  a_release: assert property (p_release)
    else $error("program mode held after release");

  property p_false_stay;
    @(posedge clk) disable iff (!rst_b)
      (st_reg.insertMode && !st_reg.falseFirst) |=> !st_reg.falseFirst;
  endproperty
  a_false_stay: assert property (p_false_stay)
    else $error("false first data set again");

  c_insert: cover property (@(posedge clk) $rose(st_reg.insertMode));
  c_write: cover property (@(posedge clk) $rose(st_reg.mZero));
  c_delay: cover property (@(posedge clk) $fell(st_reg.delIns));
endmodule // pie_insert_ctrl
`default_nettype wire

// File: tb/pie_key_model.sv
`default_nettype none
// keyboard scanner and shift register events as seen by the edit control
module pie_key_model (
  // clock
  input  wire logic             clk,
  // key and data events toward the edit control
  output var pie_pkg::pie_key_type keyIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // all keys up and no events until the bench asks
  initial begin
    keyIn = '0;
  end

  // key levels stand while a key is held down
  task automatic holdKey(input logic ins, input logic instr,
                         input logic rstKey);
    keyIn.insertKey = ins;
    keyIn.instrKey  = instr;
    keyIn.resetKey  = rstKey;
  endtask

  // slot now leaving the shift registers
  task automatic setSlot(input logic [8:0] slot);
    keyIn.slotIdx = slot;
  endtask

  // one-cycle first-data or null event, launched just after an edge
  task automatic pulseEvent(input logic isNull);
    if (isNull) begin
      keyIn.nullOut = 1'b1;
    end else begin
      keyIn.firstData = 1'b1;
    end
    @(posedge clk);
    #1;
    keyIn.nullOut   = 1'b0;
    keyIn.firstData = 1'b0;
  endtask
endmodule // pie_key_model
`default_nettype wire

// File: tb/program_insert_edit_control_test.sv
`default_nettype none
`include "pie_defs.svh"
// directed bench for the insert-mode edit control
module program_insert_edit_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk;            // 10 MHz clock
  logic                 rst_b;          // sync reset, active low
  pie_pkg::pie_key_type keyIn;          // events from key model
  logic [7:0]           keyScanData;    // counter source word
  logic [7:0]           delayedData;    // delayed path word
  logic [7:0]           directData;     // direct path word
  logic [1:0]           programModeLatch;
  logic                 modeLoadStrobeN, insertModeActiveN;
  logic                 programModePulse, keyboardSkipEnable;
  logic                 insertConstant, insertConstantN, editStatusLatch;
  logic                 keySeen, scanHalt, firstDataPending;
  logic                 markerZeroFlag, markerPendingFlag;
  logic                 insertWritePermitN, deleteInsertFlag;
  pie_pkg::pie_path_type pathSel;       // path select levels
  logic [8:0]           markerCount;    // marker counter
  logic [7:0]           shiftInData;    // word into shift registers
  int                   errorCnt;       // mismatches seen
  int                   testsRun;       // comparisons made

  pie_key_model KEY (.clk(clk), .keyIn(keyIn));

  pie_insert_ctrl DUT (
    .clk(clk), .rst_b(rst_b), .keyIn(keyIn),
    .keyScanData(keyScanData), .delayedData(delayedData),
    .directData(directData), .programModeLatch(programModeLatch),
    .modeLoadStrobeN(modeLoadStrobeN),
    .insertModeActiveN(insertModeActiveN),
    .programModePulse(programModePulse),
    .keyboardSkipEnable(keyboardSkipEnable),
    .insertConstant(insertConstant), .insertConstantN(insertConstantN),
    .editStatusLatch(editStatusLatch), .keySeen(keySeen),
    .scanHalt(scanHalt), .firstDataPending(firstDataPending),
    .markerZeroFlag(markerZeroFlag),
    .markerPendingFlag(markerPendingFlag),
    .insertWritePermitN(insertWritePermitN),
    .deleteInsertFlag(deleteInsertFlag), .pathSel(pathSel),
    .markerCount(markerCount), .shiftInData(shiftInData)
  );

  // free-running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // report the verdict and end the run
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // compare a value of up to nine bits
  task automatic chkVal(input logic [8:0] got, input logic [8:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected value at %0t: got %h expected %h",
               $time, got, exp);
    end
  endtask

  // flag picked by number for the bounded waits
  function automatic logic probe(input int id);
    case (id)
      0: probe = modeLoadStrobeN;
      1: probe = insertModeActiveN;
      2: probe = programModePulse;
      3: probe = markerPendingFlag;
      4: probe = firstDataPending;
      5: probe = markerZeroFlag;
      default: probe = deleteInsertFlag;
    endcase
  endfunction

  // wait up to lim cycles for a flag to reach a level
  task automatic waitSig(input int id, input logic val, input int lim);
    int n;
    n = 0;
    while (probe(id) !== val && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chkVal({8'h00, probe(id)}, {8'h00, val});
  endtask

  // let a number of clock edges pass, staying off the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one keyed instruction written at marker m
  task automatic insertOne(input logic [8:0] m);
    KEY.setSlot(m + 9'h003);
    KEY.holdKey(1'b0, 1'b1, 1'b0);
    waitSig(3, 1'b1, 30);
    KEY.holdKey(1'b0, 1'b0, 1'b0);
    KEY.pulseEvent(1'b0);
    waitSig(4, 1'b1, 4);
    KEY.setSlot(m);
    waitSig(5, 1'b1, 12);
    chkVal({8'h00, markerPendingFlag}, 9'h000);
    chkVal(markerCount, m - 9'h001);
    // permit and selects follow the zero flag by one registered cycle
    cycles(1);
    chkVal({8'h00, insertWritePermitN}, 9'h000);
    chkVal({1'b0, shiftInData}, {1'b0, keyScanData});
    chkVal({7'h00, pathSel}, 9'h001);
    KEY.setSlot(m + 9'h005);
    waitSig(6, 1'b1, 12);
    cycles(1);
    chkVal({7'h00, pathSel}, 9'h003);
    cycles(2);
    chkVal({1'b0, shiftInData}, {1'b0, delayedData});
    KEY.pulseEvent(1'b1);
    waitSig(6, 1'b0, 12);
    cycles(1);
    chkVal({8'h00, pathSel.delayPathSelect}, 9'h000);
    cycles(2);
    chkVal({1'b0, shiftInData}, {1'b0, directData});
    chkVal({8'h00, insertModeActiveN}, 9'h000);
  endtask

  // hang guard, far beyond the roughly 80 cycles the tests need
  initial begin
    #(5000 * 100);
    errorCnt++;
    $display("unexpected hang at %0t: got %h expected %h", $time, 0, 1);
    stopTest();
  end

  // main sequence
  initial begin
    errorCnt    = 0;
    testsRun    = 0;
    rst_b       = 1'b0;
    keyScanData = 8'ha5;
    delayedData = 8'h5a;
    directData  = 8'h3c;
    cycles(4);
    rst_b = 1'b0;
    chkVal({8'h00, modeLoadStrobeN}, 9'h001);
    chkVal({8'h00, keyboardSkipEnable}, 9'h001);
    chkVal({7'h00, programModeLatch}, {7'h00, `PIE_MODE_MANUAL});
    rst_b = 1'b1;
    cycles(1);
    chkVal(markerCount, `PIE_MARKER_RST);
    $display("test reset done");
    // insert key: key-seen, debounce, mode load
    KEY.holdKey(1'b1, 1'b0, 1'b0);
    cycles(2);
    chkVal({7'h00, keySeen, scanHalt}, 9'h003);
    waitSig(0, 1'b0, 20);
    cycles(1);
    chkVal({7'h00, programModeLatch}, {7'h00, `PIE_MODE_INSERT});
    waitSig(2, 1'b1, 4);
    waitSig(1, 1'b0, 14);
    chkVal({8'h00, modeLoadStrobeN}, 9'h001);
    chkVal({8'h00, keyboardSkipEnable}, 9'h000);
    chkVal({8'h00, programModePulse}, 9'h001);
    chkVal({7'h00, insertConstant, insertConstantN}, 9'h002);
    chkVal({8'h00, editStatusLatch}, 9'h001);
    KEY.holdKey(1'b0, 1'b0, 1'b0);
    waitSig(2, 1'b0, 4);
    $display("test insert key done");
    // two insertions back to back at a stepping marker
    insertOne(`PIE_MARKER_RST);
    insertOne(`PIE_MARKER_RST - 9'h001);
    chkVal({8'h00, keyboardSkipEnable}, 9'h000);
    $display("test insertions done");
    // reset key returns to manual mode
    KEY.holdKey(1'b0, 1'b0, 1'b1);
    cycles(1);
    KEY.holdKey(1'b0, 1'b0, 1'b0);
    waitSig(1, 1'b1, 4);
    chkVal({8'h00, editStatusLatch}, 9'h000);
    chkVal({7'h00, programModeLatch}, {7'h00, `PIE_MODE_MANUAL});
    chkVal({8'h00, keyboardSkipEnable}, 9'h001);
    $display("test reset key done");
    stopTest();
  end
endmodule // program_insert_edit_control_test
`default_nettype wire
